// ==== cpu_interrupt_exception_unit.sv ====
`timescale 1ns/1ps
// Operation
// [RULE1] Push flags, segment, pointer; load handler pointer.
// [RULE2] Table holds 256 pointers, 8-bit index.
// [RULE3] Vectors 0-31 reserved, 32-255 user.
// [RULE4] Fixed vectors for processor exceptions.
// [RULE5] Exception return points at faulting instruction.
// [RULE6] Overflow trap returns past its instruction.
// [RULE7] Exceptions and non-maskable vector internally.
// [RULE8] Software interrupts reach any vector.
// [RULE9] Controller supplies vector during acknowledge.
// [RULE10] Maskable request accepted only when enabled.
// [RULE11] Enable cleared after flag word pushed.
// [RULE12] Interrupt return restores saved flag word.
// [RULE13] Non-maskable uses vector 2, no acknowledge.
// [RULE14] Non-maskable handler blocks further requests.
// [RULE15] Non-maskable during handler latched until return.
// [RULE16] Step flag traps after next instruction.
// [RULE17] Fixed priority among simultaneous requests.
// [RULE18] Pending requests chain before handler starts.
// [RULE19] Table occupies bottom kilobyte of memory.
// [RULE20] Entry is offset word then segment word.
module cpu_interrupt_exception_unit
  import exc_unit_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_maskable_request_pin,
  input  wire logic              i_nmi_pin,
  input  wire logic              i_ovr_req,
  input  wire logic              i_boundary,
  input  wire exc_req_type       i_exc,
  input  wire logic [15:0]       i_ret_cs,
  input  wire logic [15:0]       i_fault_ip,
  input  wire logic [15:0]       i_next_ip,
  input  wire logic [15:0]       i_ss,
  input  wire logic [15:0]       i_sp,
  input  wire logic              i_flags_we,
  input  wire logic [15:0]       i_flags_wdata,
  input  wire logic              i_interrupt_return_instr,
  input  wire logic [15:0]       i_interrupt_return_instr_flags,
  input  wire logic              i_inta_valid,
  input  wire logic [VEC_W-1:0]  i_inta_vector,
  input  wire logic              i_mem_ack,
  input  wire logic [15:0]       i_mem_rdata,
  output logic                   o_inta_req,
  output mem_req_type            o_mem_req,
  output logic                   o_busy,
  output logic                   o_handler_go,
  output code_ptr_type           o_code_pointer,
  output logic [15:0]            o_flags,
  output logic [15:0]            o_sp,
  output logic [VEC_W-1:0]       o_vector,
  output logic                   o_vector_reserved
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACK, ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP, ST_RD_OFF, ST_RD_SEG, ST_CHAIN
  } state_type;

  function automatic logic [ADDR_W-1:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = {seg, 4'h0} + {4'h0, off};
  endfunction : phys

  function automatic logic is_reserved(input logic [VEC_W-1:0] vec);
    is_reserved = (vec < VEC_USER_MIN);
  endfunction : is_reserved

  state_type         state_r;
  state_type         state_nxt;
  logic [15:0]       flags_r;
  logic [15:0]       sp_r;
  logic [15:0]       ss_r;
  logic [15:0]       ret_cs_r;
  logic [15:0]       ret_ip_r;
  logic [VEC_W-1:0]  vec_r;
  code_ptr_type      ptr_r;
  mem_req_type       mem_r;
  mem_req_type       mem_nxt;
  logic              go_r;
  logic              nmi_active_r;
  logic              nmi_pend_r;
  logic [1:0]        maskable_request_pin_sync_r;
  logic [1:0]        nmi_sync_r;
  logic              nmi_prev_r;
  logic              nmi_edge;
  logic              window;
  logic              take_exc;
  logic              take_step;
  logic              take_nmi;
  logic              take_ovr;
  logic              take_int;
  logic              take_any;
  logic              mem_done;
  logic [VEC_W-1:0]  take_vec;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      maskable_request_pin_sync_r <= 2'h0;
      nmi_sync_r  <= 2'h0;
      nmi_prev_r  <= 1'b0;
    end else begin
      maskable_request_pin_sync_r <= {maskable_request_pin_sync_r[0], i_maskable_request_pin};
      nmi_sync_r  <= {nmi_sync_r[0], i_nmi_pin};
      nmi_prev_r  <= nmi_sync_r[1];
    end
  end

  assign nmi_edge = nmi_sync_r[1] & ~nmi_prev_r;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Requests are looked at on an instruction boundary, and again in the
  // chain slot right after a table fetch, before the handler runs.
  assign window    = (state_r == ST_IDLE && i_boundary) || state_r == ST_CHAIN; // [RULE18]
  assign take_exc  = window && state_r == ST_IDLE && i_exc.valid; // [RULE17]
  assign take_step = window && state_r == ST_IDLE && flags_r[TF_BIT] && !take_exc; // [RULE16]
  assign take_nmi  = window && nmi_pend_r && !nmi_active_r && !take_exc && !take_step; // [RULE14]
  assign take_ovr  = window && i_ovr_req && !nmi_active_r && !take_exc && !take_step
                     && !take_nmi; // [RULE14]
  assign take_int  = window && maskable_request_pin_sync_r[1] && flags_r[IF_BIT] && !nmi_active_r
                     && !take_exc && !take_step && !take_nmi && !take_ovr; // [RULE10]
  assign take_any  = take_exc | take_step | take_nmi | take_ovr | take_int;
  assign mem_done  = mem_r.valid && i_mem_ack;

  always_comb begin
    take_vec = i_exc.vector; // [RULE8]
    if (take_step) begin
      take_vec = VEC_STEP; // [RULE4]
    end else if (take_nmi) begin
      take_vec = VEC_NMI; // [RULE13]
    end else if (take_ovr) begin
      take_vec = VEC_SEG_OVR; // [RULE7]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_CHAIN: begin
        if (take_int) begin
          state_nxt = ST_ACK;
        end else if (take_any) begin
          state_nxt = ST_PUSH_FL; // [RULE7]
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ACK:     if (i_inta_valid) state_nxt = ST_PUSH_FL;
      ST_PUSH_FL: if (mem_done) state_nxt = ST_PUSH_CS;
      ST_PUSH_CS: if (mem_done) state_nxt = ST_PUSH_IP;
      ST_PUSH_IP: if (mem_done) state_nxt = ST_RD_OFF;
      ST_RD_OFF:  if (mem_done) state_nxt = ST_RD_SEG;
      ST_RD_SEG:  if (mem_done) state_nxt = ST_CHAIN;
      default:    state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Memory request built from the state being entered, so it is a flop.
  always_comb begin
    mem_nxt = '0;
    case (state_nxt)
      ST_PUSH_FL: begin
        mem_nxt = '{1'b1, 1'b1, phys(ss_r, sp_r - WORD_BYTES), flags_r}; // [RULE1]
        if (state_r == ST_IDLE) begin
          mem_nxt.addr = phys(i_ss, i_sp - WORD_BYTES);
        end
      end
      ST_PUSH_CS: mem_nxt = '{1'b1, 1'b1, phys(ss_r, sp_r - WORD_BYTES - WORD_BYTES),
                              ret_cs_r}; // [RULE1]
      ST_PUSH_IP: mem_nxt = '{1'b1, 1'b1, phys(ss_r, sp_r - WORD_BYTES - WORD_BYTES),
                              ret_ip_r}; // [RULE1]
      ST_RD_OFF:  mem_nxt = '{1'b1, 1'b0, TABLE_BASE + {10'h000, vec_r, 2'b00}, 16'h0000}; // [RULE19]
      ST_RD_SEG:  mem_nxt = '{1'b1, 1'b0, mem_r.addr + ENTRY_SEG_OFS, 16'h0000}; // [RULE20]
      default:    mem_nxt = '0;
    endcase
    if (state_nxt == state_r && mem_r.valid) begin
      mem_nxt = mem_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Return context, stack pointer and vector
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ret_cs_r <= 16'h0000;
      ret_ip_r <= 16'h0000;
      ss_r     <= 16'h0000;
      sp_r     <= 16'h0000;
      vec_r    <= '0;
    end else begin
      if (take_any && state_r == ST_IDLE) begin
        ret_cs_r <= i_ret_cs;
        ss_r     <= i_ss;
        sp_r     <= i_sp;
        if (take_exc && !i_exc.after && i_exc.vector != VEC_OVERFLOW) begin
          ret_ip_r <= i_fault_ip; // [RULE5]
        end else begin
          ret_ip_r <= i_next_ip; // [RULE6]
        end
      end else if (take_any) begin
        ret_cs_r <= ptr_r.seg; // [RULE18]
        ret_ip_r <= ptr_r.off;
      end else if (mem_done && mem_r.write) begin
        sp_r <= sp_r - WORD_BYTES;
      end
      if (take_any && !take_int) begin
        vec_r <= take_vec;
      end else if (state_r == ST_ACK && i_inta_valid) begin
        vec_r <= i_inta_vector; // [RULE9]
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag word
  // ----------------------------------------------------------------
  // The pushed copy is taken before the clear, so the old enable returns.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flags_r <= FLAGS_RESET;
    end else if (state_r == ST_PUSH_FL && mem_done) begin
      flags_r[IF_BIT] <= 1'b0; // [RULE11]
      flags_r[TF_BIT] <= 1'b0; // [RULE16]
    end else if (i_interrupt_return_instr) begin
      flags_r <= i_interrupt_return_instr_flags; // [RULE12]
    end else if (i_flags_we) begin
      flags_r <= i_flags_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Non-maskable tracking
  // ----------------------------------------------------------------
  // A fresh edge wins over the clear made by taking the previous one.
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nmi_pend_r   <= 1'b0;
      nmi_active_r <= 1'b0;
    end else begin
      if (nmi_edge) begin
        nmi_pend_r <= 1'b1; // [RULE15]
      end else if (take_nmi) begin
        nmi_pend_r <= 1'b0;
      end
      if (take_nmi) begin
        nmi_active_r <= 1'b1; // [RULE13]
      end else if (i_interrupt_return_instr) begin
        nmi_active_r <= 1'b0; // [RULE14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Handler pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_r <= '0;
      go_r  <= 1'b0;
    end else begin
      if (state_r == ST_RD_OFF && mem_done) begin
        ptr_r.off <= i_mem_rdata; // [RULE20]
      end
      if (state_r == ST_RD_SEG && mem_done) begin
        ptr_r.seg <= i_mem_rdata; // [RULE1]
      end
      go_r <= state_r == ST_CHAIN && !take_any; // [RULE18]
    end
  end

  assign o_inta_req        = state_r == ST_ACK;
  assign o_mem_req         = mem_r;
  assign o_busy            = state_r != ST_IDLE;
  assign o_handler_go      = go_r;
  assign o_code_pointer    = ptr_r;
  assign o_flags           = flags_r;
  assign o_sp              = sp_r;
  assign o_vector          = vec_r;
  assign o_vector_reserved = is_reserved(vec_r); // [RULE3]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_TABLE_ADDR: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE2]
    (state_r == ST_RD_OFF && mem_r.valid) |-> mem_r.addr == TABLE_BASE + {10'h000, vec_r, 2'b00}
    && mem_r.addr <= TABLE_LAST) else $error("Table address wrong.");
  AST_FLAGS_PUSH: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE11]
    (state_r == ST_PUSH_FL && mem_done) |-> mem_r.wdata == flags_r ##1 !flags_r[IF_BIT])
    else $error("Flag push or enable clear wrong.");
  AST_NMI_VEC: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE13]
    take_nmi |=> vec_r == VEC_NMI && state_r == ST_PUSH_FL) else $error("Non-maskable path wrong.");
  AST_STEP_VEC: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE16]
    take_step |=> vec_r == VEC_STEP) else $error("Step vector wrong.");
  AST_EXC_FIRST: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE17]
    (state_r == ST_IDLE && i_boundary && i_exc.valid) |=> vec_r == $past(i_exc.vector))
    else $error("Exception lost priority.");
  AST_INTO_RET: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE6]
    (take_exc && i_exc.vector == VEC_OVERFLOW) |=> ret_ip_r == $past(i_next_ip))
    else $error("Overflow trap return wrong.");
  AST_FAULT_RET: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE5]
    (take_exc && !i_exc.after && i_exc.vector != VEC_OVERFLOW) |=> ret_ip_r == $past(i_fault_ip))
    else $error("Fault return wrong.");
  AST_MASK_EN: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE10]
    $rose(o_inta_req) |-> $past(flags_r[IF_BIT]) && !$past(nmi_active_r))
    else $error("Maskable taken while disabled.");
  AST_INTERRUPT_RETURN_INSTR_FLAGS: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE12]
    (i_interrupt_return_instr && !take_nmi && !(state_r == ST_PUSH_FL && mem_done))
    |=> flags_r == $past(i_interrupt_return_instr_flags) && !nmi_active_r) else $error("Return restore wrong.");

endmodule : cpu_interrupt_exception_unit

// ==== exc_unit_pkg.sv ====
package exc_unit_pkg;

  localparam int          VEC_W         = 8;
  localparam int          ADDR_W        = 20;
  localparam logic [15:0] FLAGS_RESET   = 16'h0002;
  localparam int          IF_BIT        = 9;
  localparam int          TF_BIT        = 8;
  localparam logic [7:0]  VEC_DIVIDE    = 8'h00;
  localparam logic [7:0]  VEC_STEP      = 8'h01;
  localparam logic [7:0]  VEC_NMI       = 8'h02;
  localparam logic [7:0]  VEC_BREAK     = 8'h03;
  localparam logic [7:0]  VEC_OVERFLOW  = 8'h04;
  localparam logic [7:0]  VEC_RANGE     = 8'h05;
  localparam logic [7:0]  VEC_BAD_OP    = 8'h06;
  localparam logic [7:0]  VEC_NO_COPROC = 8'h07;
  localparam logic [7:0]  VEC_SEG_OVR   = 8'h09;
  localparam logic [7:0]  VEC_COP_ERR   = 8'h10;
  localparam logic [7:0]  VEC_USER_MIN  = 8'h20;
  localparam logic [19:0] TABLE_BASE    = 20'h00000;
  localparam logic [19:0] TABLE_LAST    = 20'h003ff;
  localparam logic [15:0] WORD_BYTES    = 16'h0002;
  localparam logic [19:0] ENTRY_SEG_OFS = 20'h00002;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } mem_req_type;

  typedef struct packed {
    logic [15:0] seg;
    logic [15:0] off;
  } code_ptr_type;

  typedef struct packed {
    logic             valid;
    logic             after;
    logic [VEC_W-1:0] vector;
  } exc_req_type;

endpackage : exc_unit_pkg

// ==== intc_model.sv ====
`timescale 1ns/1ps
module intc_model
  import exc_unit_pkg::*;
#(
  parameter int LAT = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_inta_req,
  input  wire logic [VEC_W-1:0] i_vector,
  output logic                  o_inta_valid,
  output logic [VEC_W-1:0]      o_inta_vector
);
  int cnt = 0;
  initial begin
    o_inta_valid = 1'b0;
    o_inta_vector = 8'h00;
  end
  // The vector bus is inverted every cycle between answers, so no stale value is held two cycles running.
  always @(negedge i_clk) begin
    if (o_inta_valid) begin
      o_inta_valid <= 1'b0;
      o_inta_vector <= ~o_inta_vector;
      cnt <= 0;
    end else if (i_inta_req && cnt == LAT) begin
      o_inta_valid <= 1'b1;
      o_inta_vector <= i_vector;
    end else begin
      cnt <= i_inta_req ? cnt + 1 : 0;
      o_inta_vector <= ~o_inta_vector;
    end
  end
endmodule : intc_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
  import exc_unit_pkg::*;
;
  logic         clk = 1'b0, rst = 1'b1, mreq = 1'b0, nmi = 1'b0, boundary = 1'b0;
  logic         flags_we = 1'b0, interrupt_return_instr = 1'b0, mem_ack = 1'b0, inta_seen = 1'b0, ovr = 1'b0;
  logic [15:0]  flags_wdata = 16'h0002, interrupt_return_instr_flags = 16'h0002;
  logic [15:0]  ret_cs = 16'h2345, fault_ip = 16'h0120, next_ip = 16'h0123;
  logic [15:0]  ss = 16'h1000, sp = 16'h0200, mem_rdata, flags, sp_out;
  logic [7:0]   ctl_vec = 8'h41, inta_vector, vector;
  logic         inta_valid, inta_req, busy, handler_go, vector_rsv;
  exc_req_type  exc = '0;
  mem_req_type  mem_req;
  code_ptr_type code_pointer;
  logic [19:0]  wa[$];
  logic [15:0]  wd[$];
  int           err_count = 0, checks = 0;

  cpu_interrupt_exception_unit i_dut (.i_clk(clk), .i_sys_rst(rst),
    .i_maskable_request_pin(mreq), .i_nmi_pin(nmi), .i_ovr_req(ovr),
    .i_boundary(boundary), .i_exc(exc), .i_ret_cs(ret_cs), .i_fault_ip(fault_ip),
    .i_next_ip(next_ip), .i_ss(ss), .i_sp(sp), .i_flags_we(flags_we),
    .i_flags_wdata(flags_wdata), .i_interrupt_return_instr(interrupt_return_instr),
    .i_interrupt_return_instr_flags(interrupt_return_instr_flags), .i_inta_valid(inta_valid), .i_inta_vector(inta_vector),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_inta_req(inta_req),
    .o_mem_req(mem_req), .o_busy(busy), .o_handler_go(handler_go),
    .o_code_pointer(code_pointer), .o_flags(flags), .o_sp(sp_out), .o_vector(vector),
    .o_vector_reserved(vector_rsv));
  intc_model i_ctl (.i_clk(clk), .i_inta_req(inta_req), .i_vector(ctl_vec),
    .o_inta_valid(inta_valid), .o_inta_vector(inta_vector));

  // ------------------------------------------------------------
  // Memory responder
  // ------------------------------------------------------------
  // Read data is a scramble of the address, so a wrong fetch address shows in the pointer.
  assign mem_rdata = mem_req.addr[15:0] ^ 16'hc3a5;
  always @(negedge clk) mem_ack <= mem_req.valid && !mem_ack;
  always @(posedge clk) begin
    if (mem_ack && mem_req.write) begin
      wa.push_back(mem_req.addr);
      wd.push_back(mem_req.wdata);
    end
    if (inta_req) inta_seen <= 1'b1;
  end
  initial forever #5 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic kick(input exc_req_type e);
    wa.delete();
    wd.delete();
    inta_seen = 1'b0;
    exc = e;
    boundary = 1'b1;
    cyc(1);
    boundary = 1'b0;
    exc = '0;
  endtask : kick
  task automatic set_fl(input logic [15:0] v);
    flags_wdata = v;
    flags_we = 1'b1;
    cyc(1);
    flags_we = 1'b0;
  endtask : set_fl
  task automatic do_interrupt_return_instr(input logic [15:0] v);
    interrupt_return_instr_flags = v;
    interrupt_return_instr = 1'b1;
    cyc(1);
    interrupt_return_instr = 1'b0;
    cyc(1);
  endtask : do_interrupt_return_instr
  task automatic wait_go();
    int n;
    n = 0;
    while (handler_go !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 300) begin
        err_count++;
        close_out();
      end
    end
    cyc(1);
  endtask : wait_go
  function automatic logic [31:0] entry(input logic [7:0] v);
    logic [15:0] o;
    o = {6'h00, v, 2'b00};
    return {(o + 16'h0002) ^ 16'hc3a5, o ^ 16'hc3a5};
  endfunction : entry
  task automatic serve(input logic [7:0] v, input logic [15:0] fl, input logic [15:0] ip);
    wait_go();
    chk("vector", 32'(v), 32'(vector));
    chk("reserved", 32'(v < 8'h20), 32'(vector_rsv));
    chk("pushes", 32'd3, 32'(wa.size()));
    for (int i = 0; i < 3; i++) begin
      chk("push addr", 32'({ss, 4'h0} + {4'h0, sp - 16'(2 * i + 2)}), 32'(wa[i]));
    end
    chk("push flags", 32'(fl), 32'(wd[0]));
    chk("push cs", 32'(ret_cs), 32'(wd[1]));
    chk("push ip", 32'(ip), 32'(wd[2]));
    chk("pointer", entry(v), code_pointer);
    chk("sp", 32'(sp - 16'h0006), 32'(sp_out));
    chk("flags", 32'(fl & 16'hfcff), 32'(flags));
  endtask : serve

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_exc(input logic [7:0] v, input logic aft, input logic [15:0] ip);
    set_fl(16'h0202);
    kick('{1'b1, aft, v});
    serve(v, 16'h0202, ip);
    chk("no ack cycle", 32'h0, 32'(inta_seen));
    $display("done exception %h", v);
  endtask : t_exc
  task automatic t_mask();
    mreq = 1'b1;
    cyc(4);
    kick('0);
    cyc(4);
    chk("masked busy", 32'h0, 32'(busy));
    set_fl(16'h0202);
    kick('0);
    serve(ctl_vec, 16'h0202, next_ip);
    chk("ack cycle", 32'h1, 32'(inta_seen));
    mreq = 1'b0;
    cyc(3);
    $display("done maskable");
  endtask : t_mask
  task automatic t_ovr();
    set_fl(16'h0202);
    mreq = 1'b1;
    cyc(4);
    ovr = 1'b1;
    kick('0);
    ovr = 1'b0;
    serve(VEC_SEG_OVR, 16'h0202, next_ip);
    chk("no ack cycle", 32'h0, 32'(inta_seen));
    mreq = 1'b0;
    cyc(3);
    $display("done overrun");
  endtask : t_ovr
  task automatic t_nmi();
    set_fl(16'h0202);
    nmi = 1'b1;
    cyc(4);
    kick('0);
    serve(VEC_NMI, 16'h0202, next_ip);
    chk("no ack cycle", 32'h0, 32'(inta_seen));
    nmi = 1'b0;
    cyc(2);
    nmi = 1'b1;
    set_fl(16'h0202);
    mreq = 1'b1;
    cyc(4);
    ovr = 1'b1;
    kick('0);
    ovr = 1'b0;
    cyc(4);
    chk("blocked busy", 32'h0, 32'(busy));
    mreq = 1'b0;
    cyc(4);
    do_interrupt_return_instr(16'h0002);
    chk("restored flags", 32'h0002, 32'(flags));
    kick('0);
    serve(VEC_NMI, 16'h0002, next_ip);
    nmi = 1'b0;
    do_interrupt_return_instr(16'h0002);
    $display("done nmi");
  endtask : t_nmi
  task automatic t_step();
    set_fl(16'h0102);
    kick('0);
    serve(VEC_STEP, 16'h0102, next_ip);
    $display("done step");
  endtask : t_step
  task automatic t_prio();
    set_fl(16'h0102);
    nmi = 1'b1;
    cyc(4);
    kick('{1'b1, 1'b0, VEC_BAD_OP});
    wait_go();
    chk("last vector", 32'(VEC_NMI), 32'(vector));
    chk("chain pushes", 32'd6, 32'(wa.size()));
    chk("first ip", 32'(fault_ip), 32'(wd[2]));
    chk("chain flags", 32'h0002, 32'(wd[3]));
    chk("chain addr", 32'({ss, 4'h0} + {4'h0, sp - 16'h0008}), 32'(wa[3]));
    chk("chain cs", entry(VEC_BAD_OP) >> 16, 32'(wd[4]));
    chk("chain ip", entry(VEC_BAD_OP) & 32'h0000ffff, 32'(wd[5]));
    chk("chain sp", 32'(sp - 16'h000c), 32'(sp_out));
    nmi = 1'b0;
    do_interrupt_return_instr(16'h0002);
    $display("done priority");
  endtask : t_prio

  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(3);
    t_exc(VEC_DIVIDE, 1'b0, fault_ip);
    t_exc(VEC_OVERFLOW, 1'b0, next_ip);
    t_exc(8'h80, 1'b1, next_ip);
    t_exc(8'h03, 1'b1, next_ip);
    t_mask();
    t_ovr();
    t_nmi();
    t_step();
    t_prio();
    close_out();
  end
endmodule : testbench
